// ===== inc/rl_pkg.sv
// Purpose: shared constants and types for remote/local bus control
// Assumes: 125 MHz sys_clk, bus messages decoded upstream on sys_clk
// Notes: numbers below are the shared figures; the bench repeats some as literals
package rl_pkg;

  localparam int CLK_MHZ         = 125;
  localparam int SELFTEST_US     = 1000;
  localparam int SELFTEST_CYCLES = SELFTEST_US * CLK_MHZ;
  localparam int SYNC_STAGES     = 2;

  localparam logic [4:0]  ADDR_FACTORY  = 5'h13;
  localparam logic [15:0] SWEEP_FAST_MS = 16'h000A;
  localparam logic [7:0]  ERR_SELFTEST  = 8'hE1;
  localparam logic [7:0]  KEY_PRESET    = 8'h01;
  localparam logic [7:0]  CHAR_I        = 8'h49;
  localparam logic [7:0]  CHAR_P        = 8'h50;
  localparam logic [7:0]  CASE_BIT      = 8'h20;

  typedef enum logic [2:0] {
    MSG_LISTEN,
    MSG_TALK,
    MSG_UNLISTEN,
    MSG_UNTALK,
    MSG_GTL,
    MSG_LLO,
    MSG_DATA
  } busKind_t;

  typedef struct packed {
    logic       valid;
    busKind_t   kind;
    logic [4:0] addr;
    logic [7:0] data;
  } busMsg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byteEv_t;

  typedef enum logic [1:0] {
    SWEEP_START_STOP,
    SWEEP_CW,
    SWEEP_CENTER
  } sweepMode_t;

  typedef struct packed {
    sweepMode_t  mode;
    logic        fullRange;
    logic [15:0] sweepTimeMs;
    logic        maxLevel;
  } presetCfg_t;

endpackage

// ===== src/sync_two.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs asynchronous to sys_clk
// Notes: first stage read only by the second
`timescale 1ns/1ns
module sync_two
  import rl_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // pin side
  input  wire logic [W-1:0] pinIn,
  // logic side
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_syncOut;

  always_comb
  begin
    next_stage1  = pinIn;
    next_syncOut = stage1;
    if (!nrst)
    begin
      next_stage1  = '0;
      next_syncOut = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    stage1  <= next_stage1;
    syncOut <= next_syncOut;
  end

endmodule

// ===== src/self_test_seq.sv
// Purpose: power-on self test sequencer
// Assumes: testPass valid at the end of the test window
// Notes: doneP is a one-cycle pulse at the end of the test
`timescale 1ns/1ns
module self_test_seq
  import rl_pkg::*;
#(
  parameter int CYCLES = SELFTEST_CYCLES
)
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // test result
  input  wire logic       testPass,
  // display control
  output logic            running,
  output logic            displayBlank,
  output logic            lampsOn,
  output logic            errorShow,
  output logic [7:0]      errorCode,
  output logic            doneP
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef enum logic {ST_RUN, ST_DONE} testSt_t;

  testSt_t        st;
  testSt_t        next_st;
  logic [CW-1:0]  cnt;
  logic [CW-1:0]  next_cnt;
  logic           next_errorShow;
  logic           next_doneP;

  always_comb
  begin
    next_st        = st;
    next_cnt       = cnt;
    next_errorShow = errorShow;
    next_doneP     = 1'b0;
    case (st)
      ST_RUN:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt == CW'(CYCLES - 1))
        begin
          next_st        = ST_DONE;
          next_doneP     = 1'b1;
          next_errorShow = !testPass;
        end
      end
      ST_DONE: next_st = ST_DONE;
      default: next_st = ST_RUN;
    endcase
    if (!nrst)
    begin
      next_st        = ST_RUN;
      next_cnt       = '0;
      next_errorShow = 1'b0;
      next_doneP     = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st        <= next_st;
    cnt       <= next_cnt;
    errorShow <= next_errorShow;
    doneP     <= next_doneP;
  end

  // blanking and lamp test while the test runs
  assign running      = (st == ST_RUN);
  assign displayBlank = running;
  assign lampsOn      = running;
  assign errorCode    = errorShow ? ERR_SELFTEST : 8'h00;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  test_len_a: assert property ($rose(nrst) |-> running [*8])
    else $error("self test ended too early");
  test_err_a: assert property
    (doneP && !$past(testPass) |-> errorShow && errorCode == ERR_SELFTEST)
    else $error("failed self test not shown");

endmodule

// ===== src/remote_local_bus_control.sv
// Purpose: remote/local state, address and self test of the bus port
// Assumes: busMsg decoded on sys_clk; keys debounced on sys_clk
// Notes: remote enable and address switches come from pins
`timescale 1ns/1ns
module remote_local_bus_control
  import rl_pkg::*;
#(
  parameter int TEST_CYCLES = SELFTEST_CYCLES
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // bus pins and decoded messages
  input  wire logic        renPin,
  input  wire logic [4:0]  addrSwitch,
  input  wire busMsg_t     busMsg,
  input  wire logic        talkReady,
  // front panel
  input  wire byteEv_t     keyIn,
  input  wire logic        localReturnKey,
  input  wire logic        addrFuncKey,
  input  wire logic        addrEntryValid,
  input  wire logic [4:0]  addrEntry,
  // instrument state
  input  wire logic [15:0] stateWord,
  input  wire logic        testPass,
  // panel and command outputs
  output byteEv_t          panelOut,
  output byteEv_t          cmdOut,
  output byteEv_t          talkOut,
  // status
  output logic             remoteIndicator,
  output logic             lockoutActive,
  output logic [4:0]       busAddr,
  output logic             addrShow,
  // preset
  output logic             presetP,
  output presetCfg_t       presetCfg,
  // self test
  output logic             displayBlank,
  output logic             lampsOn,
  output logic             errorShow,
  output logic [7:0]       errorCode
);

  typedef enum logic [1:0] {
    ST_LOCS,
    ST_REMS,
    ST_LWLS,
    ST_RWLS
  } rlState_t;

  function automatic logic isChar(input logic [7:0] b,
                                  input logic [7:0] c);
    isChar = ((b | CASE_BIT) == (c | CASE_BIT));
  endfunction

  // synchronised pins
  logic       renQ;
  logic [4:0] switchQ;
  logic       running;
  logic       testDoneP;

  sync_two #(.W(1)) u_sync_ren (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pinIn   (renPin),
    .syncOut (renQ)
  );

  sync_two #(.W(5)) u_sync_addr (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pinIn   (addrSwitch),
    .syncOut (switchQ)
  );

  self_test_seq #(.CYCLES(TEST_CYCLES)) u_test (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .testPass     (testPass),
    .running      (running),
    .displayBlank (displayBlank),
    .lampsOn      (lampsOn),
    .errorShow    (errorShow),
    .errorCode    (errorCode),
    .doneP        (testDoneP)
  );

  // remote/local state
  rlState_t   st;
  rlState_t   next_st;
  logic       listenFlag;
  logic       next_listenFlag;
  logic       talkFlag;
  logic       next_talkFlag;
  logic       prevI;
  logic       next_prevI;
  logic       isRemote;
  logic       isLocked;

  // message decode
  logic msgOk;
  logic ownListen;
  logic gtlHit;
  logic lloHit;
  logic dataHit;
  logic presetHit;

  assign msgOk     = busMsg.valid && !running;
  assign ownListen = msgOk && busMsg.kind == MSG_LISTEN
                     && busMsg.addr == busAddr;
  assign gtlHit    = msgOk && busMsg.kind == MSG_GTL && listenFlag;
  assign lloHit    = msgOk && busMsg.kind == MSG_LLO;
  assign dataHit   = msgOk && busMsg.kind == MSG_DATA && listenFlag;
  assign presetHit = dataHit && prevI && isChar(busMsg.data, CHAR_P);

  assign isRemote = (st == ST_REMS) || (st == ST_RWLS);
  assign isLocked = (st == ST_LWLS) || (st == ST_RWLS);

  always_comb
  begin
    next_st         = st;
    next_listenFlag = listenFlag;
    next_talkFlag   = talkFlag;
    next_prevI      = prevI;
    if (msgOk)
    begin
      case (busMsg.kind)
        MSG_LISTEN:   if (busMsg.addr == busAddr) next_listenFlag = 1'b1;
        MSG_UNLISTEN: next_listenFlag = 1'b0;
        MSG_TALK:     next_talkFlag = (busMsg.addr == busAddr);
        MSG_UNTALK:   next_talkFlag = 1'b0;
        default:      next_talkFlag = talkFlag;
      endcase
    end
    if (dataHit)
      next_prevI = isChar(busMsg.data, CHAR_I);
    case (st)
      ST_LOCS:
      begin
        if (lloHit)
          next_st = ST_LWLS;
        else if (ownListen || dataHit)
          next_st = ST_REMS;
      end
      ST_REMS:
      begin
        if (gtlHit || localReturnKey)
          next_st = ST_LOCS;
        else if (lloHit)
          next_st = ST_RWLS;
      end
      ST_LWLS:
      begin
        if (gtlHit)
          next_st = ST_LOCS;
        else if (ownListen || dataHit)
          next_st = ST_RWLS;
      end
      ST_RWLS:
      begin
        if (gtlHit)
          next_st = ST_LOCS;
      end
      default: next_st = ST_LOCS;
    endcase
    if (!renQ)
      next_st = ST_LOCS;
    if (!nrst)
    begin
      next_st         = ST_LOCS;
      next_listenFlag = 1'b0;
      next_talkFlag   = 1'b0;
      next_prevI      = 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st         <= next_st;
    listenFlag <= next_listenFlag;
    talkFlag   <= next_talkFlag;
    prevI      <= next_prevI;
  end

  // indicators, keys, commands, address, preset
  logic       panelOpen;
  logic       keyPreset;
  logic       next_remoteIndicator;
  logic       next_lockoutActive;
  byteEv_t    next_panelOut;
  byteEv_t    next_cmdOut;
  logic [4:0] next_busAddr;
  logic       next_addrShow;
  logic       next_presetP;
  presetCfg_t next_presetCfg;

  assign panelOpen = !isRemote && !running;
  assign keyPreset = keyIn.valid && panelOpen && keyIn.data == KEY_PRESET;

  always_comb
  begin
    next_remoteIndicator = isRemote;
    next_lockoutActive   = isLocked;
    next_panelOut.valid  = keyIn.valid && panelOpen;
    next_panelOut.data   = keyIn.data;
    next_cmdOut.valid    = dataHit;
    next_cmdOut.data     = busMsg.data;
    next_busAddr         = busAddr;
    next_addrShow        = addrShow;
    if (testDoneP)
      next_busAddr = switchQ;
    if (addrEntryValid && addrShow && panelOpen)
    begin
      next_busAddr  = addrEntry;
      next_addrShow = 1'b0;
    end
    if (addrFuncKey && panelOpen)
      next_addrShow = 1'b1;
    next_presetP   = testDoneP || presetHit || keyPreset;
    next_presetCfg = presetCfg;
    if (next_presetP)
    begin
      next_presetCfg.mode        = SWEEP_START_STOP;
      next_presetCfg.fullRange   = 1'b1;
      next_presetCfg.sweepTimeMs = SWEEP_FAST_MS;
      next_presetCfg.maxLevel    = 1'b1;
    end
    if (!nrst)
    begin
      next_remoteIndicator = 1'b0;
      next_lockoutActive   = 1'b0;
      next_panelOut        = '0;
      next_cmdOut          = '0;
      next_busAddr         = ADDR_FACTORY;
      next_addrShow        = 1'b0;
      next_presetP         = 1'b0;
      next_presetCfg       = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    remoteIndicator <= next_remoteIndicator;
    lockoutActive   <= next_lockoutActive;
    panelOut        <= next_panelOut;
    cmdOut          <= next_cmdOut;
    busAddr         <= next_busAddr;
    addrShow        <= next_addrShow;
    presetP         <= next_presetP;
    presetCfg       <= next_presetCfg;
  end

  // talker: state word sent high byte then low byte
  logic    talkIdx;
  logic    next_talkIdx;
  byteEv_t next_talkOut;

  always_comb
  begin
    next_talkIdx = talkIdx;
    next_talkOut = '0;
    if (talkFlag && talkReady && !running)
    begin
      next_talkOut.valid = 1'b1;
      next_talkOut.data  = talkIdx ? stateWord[7:0] : stateWord[15:8];
      next_talkIdx       = !talkIdx;
    end
    if (!talkFlag)
      next_talkIdx = 1'b0;
    if (!nrst)
    begin
      next_talkIdx = 1'b0;
      next_talkOut = '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    talkIdx <= next_talkIdx;
    talkOut <= next_talkOut;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence presetCodeS;
    dataHit && isChar(busMsg.data, CHAR_I) ##1 dataHit
      && isChar(busMsg.data, CHAR_P);
  endsequence

  reset_local_a: assert property
    ($rose(nrst) |-> !remoteIndicator && !lockoutActive)
    else $error("not local after reset");
  enter_remote_a: assert property
    (ownListen && renQ && !localReturnKey |=> ##1 remoteIndicator)
    else $error("listen address did not give remote");
  panel_block_a: assert property
    (keyIn.valid && isRemote |=> !panelOut.valid)
    else $error("panel key passed in remote");
  local_key_a: assert property
    (st == ST_REMS && localReturnKey |=> st == ST_LOCS)
    else $error("local key ignored in remote");
  lockout_hold_a: assert property
    (st == ST_RWLS && localReturnKey && !gtlHit && renQ |=> isRemote)
    else $error("local key left lockout");
  gtl_clear_a: assert property
    (gtlHit |=> !isRemote && !isLocked)
    else $error("go-to-local did not clear");
  bus_local_a: assert property
    (!renQ |=> ##1 !remoteIndicator)
    else $error("remote without remote enable");
  preset_code_a: assert property
    (presetCodeS |=> presetP && presetCfg.sweepTimeMs == SWEEP_FAST_MS)
    else $error("preset code did not preset");
  addr_entry_a: assert property
    (addrEntryValid && addrShow && panelOpen && !testDoneP
      |=> busAddr == $past(addrEntry))
    else $error("panel address not taken");
  indicator_a: assert property
    (##1 remoteIndicator == $past(isRemote))
    else $error("remote indicator wrong");

endmodule

// ===== tb/bus_ctrl_model.sv
// Purpose: bus controller model driving decoded bus messages
// Assumes: messages change shortly after the rising clock edge
// Notes: released message address and data show inverted values
`timescale 1ns/1ns
module bus_ctrl_model
  import rl_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // bus side
  output busMsg_t   busMsg,
  output logic      renPin
);
  initial
  begin
    busMsg = '0;
    renPin = 1'b0;
  end

  // one message, valid for one cycle
  task automatic send(input busKind_t k, input logic [4:0] a,
                      input logic [7:0] d);
    @(posedge sys_clk) #1;
    busMsg = '{1'b1, k, a, d};
    @(posedge sys_clk) #1;
    busMsg = '{1'b0, k, ~a, ~d};
  endtask

  // two messages back to back, one cycle each
  task automatic sendPair(input busKind_t k, input logic [4:0] a,
                          input logic [7:0] d0, input logic [7:0] d1);
    @(posedge sys_clk) #1;
    busMsg = '{1'b1, k, a, d0};
    @(posedge sys_clk) #1;
    busMsg = '{1'b1, k, a, d1};
    @(posedge sys_clk) #1;
    busMsg = '{1'b0, k, ~a, ~d1};
  endtask

  // bus-wide remote enable level
  task automatic setRen(input logic v);
    @(posedge sys_clk) #1;
    renPin = v;
  endtask
endmodule

// ===== tb/tb_remote_local_bus_control.sv
// Purpose: self-checking bench for remote/local bus control
// Assumes: short self test of 16 cycles
// Notes: byte events are checked against a queue of notes
`timescale 1ns/1ns
module tb_remote_local_bus_control;
  import rl_pkg::*;
  localparam int TC = 16;
  logic        sys_clk = 1'b0;
  logic        nrst;
  logic        renPin;
  logic [4:0]  addrSwitch;
  busMsg_t     busMsg;
  logic        talkReady;
  byteEv_t     keyIn;
  logic        localReturnKey;
  logic        addrFuncKey;
  logic        addrEntryValid;
  logic [4:0]  addrEntry;
  logic [15:0] stateWord;
  logic        testPass;
  byteEv_t     panelOut;
  byteEv_t     cmdOut;
  byteEv_t     talkOut;
  logic        remoteIndicator;
  logic        lockoutActive;
  logic [4:0]  busAddr;
  logic        addrShow;
  logic        presetP;
  presetCfg_t  presetCfg;
  logic        displayBlank;
  logic        lampsOn;
  logic        errorShow;
  logic [7:0]  errorCode;
  int          fail_count;
  int          checks;
  int          presetSeen;
  int          presetExp;
  int          seed;
  logic [9:0]  expQ[$];
  logic [7:0]  rb;
  logic [4:0]  wa;
  presetCfg_t  cfgExp;

  always #4 sys_clk = ~sys_clk;

  bus_ctrl_model u_bus (.sys_clk(sys_clk), .busMsg(busMsg), .renPin(renPin));

  remote_local_bus_control #(.TEST_CYCLES(TC)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .renPin(renPin),
    .addrSwitch(addrSwitch), .busMsg(busMsg), .talkReady(talkReady),
    .keyIn(keyIn), .localReturnKey(localReturnKey),
    .addrFuncKey(addrFuncKey), .addrEntryValid(addrEntryValid),
    .addrEntry(addrEntry), .stateWord(stateWord), .testPass(testPass),
    .panelOut(panelOut), .cmdOut(cmdOut), .talkOut(talkOut),
    .remoteIndicator(remoteIndicator), .lockoutActive(lockoutActive),
    .busAddr(busAddr), .addrShow(addrShow), .presetP(presetP),
    .presetCfg(presetCfg), .displayBlank(displayBlank),
    .lampsOn(lampsOn), .errorShow(errorShow), .errorCode(errorCode));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic key(input logic [7:0] d, input logic acc);
    @(posedge sys_clk) #1;
    keyIn = '{1'b1, d};
    if (acc)
      expQ.push_back({2'd2, d});
    @(posedge sys_clk) #1;
    keyIn = '{1'b0, ~d};
  endtask

  task automatic pulse(input int w);
    @(posedge sys_clk) #1;
    case (w)
      0: localReturnKey = 1'b1;
      1: addrFuncKey = 1'b1;
      default: addrEntryValid = 1'b1;
    endcase
    @(posedge sys_clk) #1;
    localReturnKey = 1'b0;
    addrFuncKey = 1'b0;
    addrEntryValid = 1'b0;
  endtask

  task automatic data(input logic [7:0] d);
    expQ.push_back({2'd0, d});
    u_bus.send(MSG_DATA, 5'h00, d);
  endtask

  task automatic dataPair(input logic [7:0] a, input logic [7:0] b);
    expQ.push_back({2'd0, a});
    expQ.push_back({2'd0, b});
    u_bus.sendPair(MSG_DATA, 5'h00, a, b);
  endtask

  task automatic waitTest();
    int i;
    i = 0;
    while (displayBlank !== 1'b0 && i < 200)
    begin
      tick(1);
      i++;
    end
    if (i == 200)
    begin
      fail_count++;
      print_verdict();
    end
    tick(2);
  endtask

  task automatic chkOut(input byteEv_t ev, input logic [1:0] s);
    logic [9:0] e;
    if (ev.valid !== 1'b0)
    begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 10'h3FF;
      chk("byte event", {22'h0, e}, {22'h0, s, ev.data});
    end
  endtask

  // watcher: takes the oldest note when a byte event appears
  always @(negedge sys_clk)
  begin
    if (presetP === 1'b1)
      presetSeen++;
    chkOut(cmdOut, 2'd0);
    chkOut(talkOut, 2'd1);
    chkOut(panelOut, 2'd2);
  end

  initial
  begin
    seed = 32'h51474DCD;
    nrst = 1'b0;
    addrSwitch = 5'h13;
    talkReady = 1'b0;
    keyIn = '0;
    localReturnKey = 1'b0;
    addrFuncKey = 1'b0;
    addrEntryValid = 1'b0;
    addrEntry = 5'h00;
    stateWord = 16'($random(seed));
    testPass = 1'b1;
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'b1;
    tick(2);
    chk("blank lamps", 2'b11, {displayBlank, lampsOn});
    chk("rem lock", 2'b00, {remoteIndicator, lockoutActive});
    presetExp = 1;
    waitTest();
    chk("power-on preset", presetExp, presetSeen);
    cfgExp = '{SWEEP_START_STOP, 1'b1, 16'h000A, 1'b1};
    chk("preset cfg", cfgExp, presetCfg);
    chk("switch address", 5'h13, busAddr);
    $display("test power-on done");
    rb = 8'($random(seed)) | 8'h80;
    key(rb, 1'b1);
    key(KEY_PRESET, 1'b1);
    presetExp++;
    tick(3);
    chk("local preset key", presetExp, presetSeen);
    $display("test local keys done");
    u_bus.setRen(1'b1);
    tick(2);
    wa = 5'h13 ^ (5'($random(seed)) | 5'h01);
    u_bus.send(MSG_LISTEN, wa, 8'h00);
    tick(3);
    chk("other address", 1'b0, remoteIndicator);
    u_bus.send(MSG_LISTEN, 5'h13, 8'h00);
    tick(2);
    chk("enter remote", 1'b1, remoteIndicator);
    key(rb, 1'b0);
    key(KEY_PRESET, 1'b0);
    tick(3);
    chk("remote keys ignored", presetExp, presetSeen);
    pulse(0);
    tick(2);
    chk("local return", 1'b0, remoteIndicator);
    $display("test remote done");
    dataPair(CHAR_I, CHAR_P);
    presetExp++;
    tick(3);
    chk("data preset", presetExp, presetSeen);
    chk("data remote", 1'b1, remoteIndicator);
    data(8'h30 | (8'($random(seed)) & 8'h09));
    tick(3);
    $display("test listener data done");
    u_bus.send(MSG_LLO, 5'h00, 8'h00);
    tick(2);
    chk("lockout", 1'b1, lockoutActive);
    pulse(0);
    tick(2);
    chk("lockout holds remote", 1'b1, remoteIndicator);
    u_bus.send(MSG_GTL, 5'h13, 8'h00);
    tick(2);
    chk("go to local", 2'b00, {remoteIndicator, lockoutActive});
    $display("test lockout done");
    u_bus.send(MSG_LISTEN, 5'h13, 8'h00);
    tick(2);
    u_bus.setRen(1'b0);
    tick(4);
    chk("bus-wide local", 1'b0, remoteIndicator);
    pulse(1);
    tick(1);
    chk("address shown", 1'b1, addrShow);
    addrEntry = wa;
    pulse(2);
    tick(1);
    chk("new address", {1'b0, wa}, {addrShow, busAddr});
    $display("test address done");
    u_bus.setRen(1'b1);
    stateWord = 16'($random(seed));
    u_bus.send(MSG_TALK, wa, 8'h00);
    expQ.push_back({2'd1, stateWord[15:8]});
    expQ.push_back({2'd1, stateWord[7:0]});
    talkReady = 1'b1;
    tick(2);
    talkReady = 1'b0;
    u_bus.send(MSG_UNTALK, 5'h00, 8'h00);
    tick(3);
    $display("test talker done");
    nrst = 1'b0;
    testPass = 1'b0;
    addrSwitch = 5'h0C;
    tick(6);
    nrst = 1'b1;
    presetExp++;
    waitTest();
    chk("reset preset", presetExp, presetSeen);
    chk("error", {1'b1, ERR_SELFTEST}, {errorShow, errorCode});
    chk("address reread", 5'h0C, busAddr);
    chk("notes left", 0, expQ.size());
    $display("test self test fail done");
    print_verdict();
  end
endmodule
